// [wdt_supervisor_pkg.sv]
// constants and types for the watchdog reset supervisor
package wdt_supervisor_pkg;
    // clock 250 MHz
    localparam int unsigned CLK_PERIOD_PS     = 4000;
    // timing scale: 2.67 us per pF = 2670000 ps per pF
    localparam int unsigned PS_PER_PF         = 2670000;
    localparam int unsigned CYCLES_PER_PF     = PS_PER_PF / CLK_PERIOD_PS;
    // default capacitances, picofarads
    localparam int unsigned RESET_CAP_PF_DEF  = 100;
    localparam int unsigned WDOG_CAP_PF_DEF   = 1000;
    localparam int unsigned EXT_MULT          = 500;
    // glitch filter: excursions of 50 us or less are ignored
    localparam int unsigned GLITCH_NS         = 50000;
    localparam int unsigned GLITCH_CYC        =
        (GLITCH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // keeper pulse at about 94 percent of the period, high phase
    localparam int unsigned KEEP_PCT          = 94;
    localparam int unsigned KEEP_HIGH_NS      = 40;
    localparam int unsigned KEEP_HIGH_CYC     =
        (KEEP_HIGH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int          CNT_W             = 40;
    localparam int          FLT_W             = 16;

    typedef enum logic [1:0] {
        ST_HOLD = 2'b00,
        ST_RUN  = 2'b01,
        ST_UV   = 2'b11
    } sup_state_type;
endpackage

// [watchdog_reset_supervisor.sv]
// watchdog and reset supervisor top
// Functional notes
// RQ1 - reset hold period is a parameterised count, 2.67 us per picofarad.
// RQ2 - normal watchdog period is a parameterised count, 2.67 us per pF.
// RQ3 - with mode select high the watchdog period is 500 times longer.
// RQ4 - an unserviced watchdog period asserts the reset output.
// RQ5 - a monitored input pulled to zero starts a reset.
// RQ6 - after the input returns reset holds for the full hold period.
// RQ7 - open-drain reset line may be pulled low by either party only.
// RQ8 - input dips of 50 us or less are filtered out.
// RQ9 - extended mode with service undriven self-services by a pulse.
// RQ10 - processor services with a low-high-low pulse once per period.
// RQ11 - normal mode disables the keeper; service is a plain input.
// RQ12 - processor sets mode high before sleep, low while executing.
// RQ13 - watchdog count is cleared through reset and restarts at zero.
// RQ14 - any edge on service or mode select clears the watchdog count.
// RQ15 - reset holds while input is low, then for the hold period.
// RQ16 - all periods come from one timebase; keeper fires before expiry.
// RQ17 - service, mode and undervoltage inputs are synchronised first.
`timescale 1ns/1ps
`default_nettype none
module watchdog_reset_supervisor
    import wdt_supervisor_pkg::*;
#(
    parameter logic [39:0] RESET_HOLD_CYC =
        40'(wdt_supervisor_pkg::RESET_CAP_PF_DEF)
        * 40'(wdt_supervisor_pkg::CYCLES_PER_PF),
    parameter logic [39:0] WDOG_CYC =
        40'(wdt_supervisor_pkg::WDOG_CAP_PF_DEF)
        * 40'(wdt_supervisor_pkg::CYCLES_PER_PF)
) (
    // clock and control
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic clk_en,
    // monitored input, high while below trip level
    input  wire logic undervoltage,
    // processor side
    input  wire logic watchdog_service_input,
    input  wire logic watchdog_service_driven,
    input  wire logic watchdog_mode_select,
    // keeper drive of the service pin
    output logic      keeper_out,
    output logic      keeper_oe,
    // reset line, open drain active low
    input  wire logic reset_line_in,
    output logic      reset_n_out,
    output logic      reset_n_oe,
    // push-pull active high view
    output logic      reset_active
);
    import wdt_supervisor_pkg::*;

    localparam logic [39:0] EXT_CYC  = WDOG_CYC * 40'(EXT_MULT);
    localparam logic [39:0] NKEEP    = WDOG_CYC * 40'(KEEP_PCT) / 40'd100;
    localparam logic [39:0] EKEEP    = EXT_CYC * 40'(KEEP_PCT) / 40'd100;
    localparam logic [15:0] GLT      = 16'(GLITCH_CYC);
    localparam logic [3:0]  KHI      = 4'(KEEP_HIGH_CYC);

    // synchronisers [RQ17]
    logic [1:0] s_svc, s_mode, s_uv;
    logic       p_svc, p_mode;
    logic [1:0] next_s_svc, next_s_mode, next_s_uv;
    logic       next_p_svc, next_p_mode;
    always_comb begin
        next_s_svc  = {s_svc[0], watchdog_service_input};
        next_s_mode = {s_mode[0], watchdog_mode_select};
        next_s_uv   = {s_uv[0], undervoltage};
        next_p_svc  = s_svc[1];
        next_p_mode = s_mode[1];
    end
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_svc  <= 2'b00;
            s_mode <= 2'b00;
            s_uv   <= 2'b00;
            p_svc  <= 1'b0;
            p_mode <= 1'b0;
        end else if (clk_en) begin
            s_svc  <= next_s_svc;
            s_mode <= next_s_mode;
            s_uv   <= next_s_uv;
            p_svc  <= next_p_svc;
            p_mode <= next_p_mode;
        end
    end

    wire logic ext_mode = s_mode[1];
    wire logic svc_edge = s_svc[1] ^ p_svc;
    wire logic mode_edge = s_mode[1] ^ p_mode;

    // glitch filter on undervoltage [RQ8]
    logic [FLT_W-1:0] flt_cnt, next_flt_cnt;
    logic             uv_flt, next_uv_flt;
    always_comb begin
        next_flt_cnt = '0;
        next_uv_flt  = uv_flt;
        if (s_uv[1]) begin
            if (flt_cnt > GLT) begin
                next_uv_flt  = 1'b1;
                next_flt_cnt = flt_cnt;
            end else begin
                next_flt_cnt = flt_cnt + 16'd1;
            end
        end else begin
            next_uv_flt = 1'b0;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            flt_cnt <= '0;
            uv_flt  <= 1'b0;
        end else if (clk_en) begin
            flt_cnt <= next_flt_cnt;
            uv_flt  <= next_uv_flt;
        end
    end

    // main supervisor sequence
    sup_state_type    state, next_state;
    logic [CNT_W-1:0] hold_cnt, next_hold_cnt;
    logic [CNT_W-1:0] wd_cnt, next_wd_cnt;
    logic [CNT_W-1:0] wd_limit, keep_at;
    logic             keep_pulse;

    always_comb begin
        wd_limit = ext_mode ? EXT_CYC : WDOG_CYC;       // [RQ2] [RQ3]
        keep_at  = ext_mode ? EKEEP : NKEEP;            // [RQ16]
    end

    // keeper pulse only in extended mode with pin undriven [RQ9] [RQ11]
    always_comb begin
        keep_pulse = ext_mode && !watchdog_service_driven
                     && state == ST_RUN
                     && wd_cnt == keep_at;
    end

    always_comb begin
        next_state    = state;
        next_hold_cnt = hold_cnt;
        next_wd_cnt   = wd_cnt;
        case (state)
            ST_UV: begin
                next_hold_cnt = '0;
                next_wd_cnt   = '0;                     // [RQ13]
                if (!uv_flt) begin
                    next_state = ST_HOLD;
                end
            end
            ST_HOLD: begin
                next_wd_cnt = '0;                       // [RQ13]
                if (uv_flt) begin
                    next_state = ST_UV;                 // [RQ5]
                end else if (hold_cnt >= RESET_HOLD_CYC - 40'd1) begin
                    next_state = ST_RUN;                // [RQ1] [RQ6]
                    next_hold_cnt = '0;
                end else begin
                    next_hold_cnt = hold_cnt + 40'd1;   // [RQ15]
                end
            end
            ST_RUN: begin
                next_hold_cnt = '0;
                if (uv_flt) begin
                    next_state  = ST_UV;                // [RQ15]
                    next_wd_cnt = '0;
                end else if (svc_edge || mode_edge) begin
                    next_wd_cnt = '0;                   // [RQ14]
                end else if (wd_cnt >= wd_limit - 40'd1) begin
                    next_state  = ST_HOLD;              // [RQ4]
                    next_wd_cnt = '0;
                end else begin
                    next_wd_cnt = wd_cnt + 40'd1;       // [RQ16]
                end
            end
            default: begin
                next_state    = ST_HOLD;
                next_hold_cnt = '0;
                next_wd_cnt   = '0;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state    <= ST_HOLD;
            hold_cnt <= '0;
            wd_cnt   <= '0;
        end else if (clk_en) begin
            state    <= next_state;
            hold_cnt <= next_hold_cnt;
            wd_cnt   <= next_wd_cnt;
        end
    end

    // registered outputs
    logic       next_rst_act, next_keep_out, next_keep_oe;
    logic [3:0] keep_cnt, next_keep_cnt;
    always_comb begin
        next_rst_act  = next_state != ST_RUN;
        next_keep_oe  = ext_mode && !watchdog_service_driven;  // [RQ11]
        next_keep_cnt = keep_cnt;
        if (keep_pulse) begin
            next_keep_cnt = KHI;                               // [RQ9]
        end else if (keep_cnt != 4'h0) begin
            next_keep_cnt = keep_cnt - 4'h1;
        end
        // stretched, as the pulse's own edge clears the count early
        next_keep_out = next_keep_oe && next_keep_cnt != 4'h0; // [RQ9]
    end
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            reset_active <= 1'b1;
            keeper_oe    <= 1'b0;
            keeper_out   <= 1'b0;
            keep_cnt     <= 4'h0;
        end else if (clk_en) begin
            reset_active <= next_rst_act;
            keeper_oe    <= next_keep_oe;
            keeper_out   <= next_keep_out;
            keep_cnt     <= next_keep_cnt;
        end
    end

    // open drain: drive low only, never high [RQ7]
    always_comb begin
        reset_n_out = 1'b0;
        reset_n_oe  = reset_active;
    end

    logic unused_line;
    always_comb unused_line = reset_line_in;
endmodule
`default_nettype wire

// [wdt_cpu_model.sv]
// processor model on the far side of the supervisor
`timescale 1ns/1ps
`default_nettype none
module wdt_cpu_model (
    // bench requests
    input  wire logic clk_sys,
    input  wire logic drive,
    input  wire logic pulse,
    input  wire logic ext,
    // supervisor pins
    input  wire logic keeper_out,
    input  wire logic keeper_oe,
    input  wire logic reset_n_oe,
    output logic      svc,
    output logic      driven,
    output logic      mode,
    output logic      line
);
    int   hi = 0;
    logic last = 1'b0;
    always @(posedge clk_sys) begin
        hi <= pulse ? 10 : (hi > 0 ? hi - 1 : 0);
        last <= svc;
    end
    assign driven = drive;
    assign mode   = ext;
    // undriven, unkept pin shows no stable level
    assign svc  = drive ? (hi > 0) : (keeper_oe ? keeper_out : ~last);
    assign line = ~reset_n_oe;
endmodule
`default_nettype wire

// [wdt_sup_asserts.sv]
// assertions for the watchdog reset supervisor
`timescale 1ns/1ps
`default_nettype none
module wdt_sup_asserts #(
    parameter logic [39:0] RESET_HOLD_CYC = 40'h14,
    parameter logic [39:0] WDOG_CYC       = 40'h64
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic undervoltage,
    input wire logic watchdog_service_input,
    input wire logic watchdog_mode_select,
    input wire logic watchdog_service_driven,
    input wire logic keeper_out,
    input wire logic keeper_oe,
    input wire logic reset_n_out,
    input wire logic reset_n_oe,
    input wire logic reset_active
);
    int hi;
    int lo;
    always_ff @(posedge clk_sys) begin
        hi <= reset_active ? hi + 1 : 0;
        lo <= (reset_active
            || watchdog_mode_select != $past(watchdog_mode_select)
            || watchdog_service_input != $past(watchdog_service_input))
            ? 0 : lo + 1;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_keep; keeper_out [*8]; endsequence
    sequence s_ext; (watchdog_mode_select && !watchdog_service_driven
        && !reset_active) [*6]; endsequence
    property p_od; reset_n_oe == reset_active && !reset_n_out; endproperty
    a_od: assert property (p_od) else $error("open drain");
    property p_rst; $fell(rst) |-> reset_active; endproperty
    a_rst: assert property (p_rst) else $error("reset");
    property p_hold; $fell(reset_active) |-> hi >= RESET_HOLD_CYC; endproperty
    a_hold: assert property (p_hold) else $error("hold");
    property p_wd; !reset_active && !watchdog_mode_select
        |-> lo <= WDOG_CYC + 8; endproperty
    a_wd: assert property (p_wd) else $error("expiry");
    property p_early; $rose(reset_active)
        |-> undervoltage || lo + 2 >= WDOG_CYC; endproperty
    a_early: assert property (p_early) else $error("early");
    property p_koff; (!watchdog_mode_select) [*6] |-> !keeper_oe; endproperty
    a_koff: assert property (p_koff) else $error("keeper");
    property p_kon; s_ext |-> keeper_oe; endproperty
    a_kon: assert property (p_kon) else $error("keeper");
    property p_kpul; $rose(keeper_out) |-> s_keep; endproperty
    a_kpul: assert property (p_kpul) else $error("pulse");
endmodule
bind watchdog_reset_supervisor wdt_sup_asserts #(
    .RESET_HOLD_CYC(RESET_HOLD_CYC), .WDOG_CYC(WDOG_CYC)) chk (
    .clk_sys, .rst, .undervoltage, .watchdog_service_input,
    .watchdog_mode_select, .watchdog_service_driven, .keeper_out,
    .keeper_oe, .reset_n_out, .reset_n_oe, .reset_active);
`default_nettype wire

// [test_watchdog_reset_supervisor.sv]
// self-checking bench for the watchdog reset supervisor
`timescale 1ns/1ps
`default_nettype none
module test_watchdog_reset_supervisor;
    import wdt_supervisor_pkg::*;
    localparam int HOLD = 20;
    localparam int WD   = 100;
    logic clk_sys = 0, rst = 1, uv = 0, drv = 1, pls = 0, ext = 0;
    logic svc, dvn, mode, line, kout, koe, rno, rnoe, ract;
    int   fails = 0, compares = 0, n;
    logic [15:0] rnd = 16'hafc8;
    always #2 clk_sys = ~clk_sys;
    watchdog_reset_supervisor #(.RESET_HOLD_CYC(40'h14),
        .WDOG_CYC(40'h64)) uut (.clk_sys, .rst, .clk_en(1'b1),
        .undervoltage(uv), .watchdog_service_input(svc),
        .watchdog_service_driven(dvn), .watchdog_mode_select(mode),
        .keeper_out(kout), .keeper_oe(koe), .reset_line_in(line),
        .reset_n_out(rno), .reset_n_oe(rnoe), .reset_active(ract));
    wdt_cpu_model cpu (.clk_sys, .drive(drv), .pulse(pls), .ext,
        .keeper_out(kout), .keeper_oe(koe), .reset_n_oe(rnoe), .svc,
        .driven(dvn), .mode, .line);
    function automatic logic [15:0] lfsr(logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    task check(string nm, logic e, logic g);
        compares++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s exp %b got %b", nm, e, g);
        end
    endtask
    task step(int c);
        repeat (c) @(posedge clk_sys);
        #1;
    endtask
    task wait_ract(logic v, int lim);
        n = 0;
        while (ract !== v && n < lim) begin
            step(1);
            n++;
        end
    endtask
    task results;
        $display("fails %0d compares %0d", fails, compares);
        if (fails == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        #400000;
        fails++;
        results;
    end
    initial begin
        step(16);
        rst = 0;
        wait_ract(0, 200);
        check("hold", 1, n >= HOLD && n <= HOLD + 4);
        wait_ract(1, 400);
        check("expiry", 1, n >= WD && n <= WD + 6);
        wait_ract(0, 200);
        repeat (40) begin
            rnd = lfsr(rnd);
            if (rnd[0]) pls = 1;
            else ext = ~ext;
            step(1);
            pls = 0;
            step(12 + rnd[7:1] % 60);
            check("serviced", 0, ract);
        end
        ext = 1;
        drv = 0;
        step(20);
        uv = 1;
        step(12400);
        uv = 0;
        step(10);
        check("glitch", 0, ract);
        uv = 1;
        step(12600);
        check("uv trip", 1, ract);
        uv = 0;
        wait_ract(0, 100);
        check("uv hold", 1, n >= HOLD && n <= HOLD + 8);
        // without the keeper the extended period ends inside this span
        wait_ract(1, 52000);
        check("keeper", 0, ract);
        results;
    end
endmodule
`default_nettype wire
